// file: ftx_pkg.sv
// package for the fsk modem transmit usart
package ftx_pkg;
    // register byte offsets
    localparam logic [7:0] FTX_OFF_DATA   = 8'h00;
    localparam logic [7:0] FTX_OFF_MODE   = 8'h04;
    localparam logic [7:0] FTX_OFF_STAT   = 8'h08;
    localparam logic [7:0] FTX_OFF_IEN    = 8'h0C;
    localparam logic [7:0] FTX_OFF_ICLR   = 8'h10;
    localparam logic [7:0] FTX_OFF_RXMODE = 8'h14;
    // mode register fields
    localparam int FTX_MD_TYPE_LSB = 0;   // 4 bits, modem type
    localparam int FTX_MD_FMT_LSB  = 4;   // 2 bits, data format
    localparam int FTX_MD_LEN_LSB  = 6;   // 2 bits, data bits minus 5
    localparam int FTX_MD_PEN      = 8;
    localparam int FTX_MD_PODD     = 9;
    localparam int FTX_MD_STOP2    = 10;
    localparam int FTX_MD_PAT_LSB  = 12;  // 2 bits, continuous pattern
    localparam int FTX_MD_PSAVE    = 15;
    localparam logic [15:0] FTX_MODE_RST = 16'h0000;
    // status bits
    localparam int FTX_ST_READY = 0;
    localparam int FTX_ST_UNDER = 1;
    // modem / transmit types
    localparam logic [3:0] FTX_T_OFF     = 4'h0;
    localparam logic [3:0] FTX_T_B103    = 4'h1;
    localparam logic [3:0] FTX_T_V23_HI  = 4'h2;
    localparam logic [3:0] FTX_T_V23_LO  = 4'h3;
    localparam logic [3:0] FTX_T_B202_HI = 4'h4;
    localparam logic [3:0] FTX_T_B202_LO = 4'h5;
    localparam logic [3:0] FTX_T_DTMF    = 4'h6;
    localparam logic [3:0] FTX_T_TONE    = 4'h7;
    localparam logic [3:0] FTX_T_USER    = 4'h8;
    // formats
    localparam logic [1:0] FTX_F_SYNC = 2'h0;
    localparam logic [1:0] FTX_F_SS   = 2'h1;
    localparam logic [1:0] FTX_F_PAT  = 2'h2;
    // bit timing
    localparam int FTX_CLK_HZ   = 100_000_000;
    localparam int FTX_DIV_300  = FTX_CLK_HZ / 300;
    localparam int FTX_DIV_1200 = FTX_CLK_HZ / 1200;
    localparam int FTX_DIV_75   = FTX_CLK_HZ / 75;
    localparam int FTX_DIV_150  = FTX_CLK_HZ / 150;
    localparam int FTX_DIV_W    = 24;
endpackage : ftx_pkg

// file: ftx_rate_if.sv
// rate divider carrier between the usart and its baud generator
`timescale 1ns/1ps
`default_nettype none
interface ftx_rate_if;
    logic [23:0] div;
    logic        run;
    logic        tick;
    modport gen (input div, input run, output tick);
    modport user (output div, output run, input tick);
endinterface : ftx_rate_if
`default_nettype wire

// file: ftx_baud.sv
// baud-rate enable generator
`timescale 1ns/1ps
`default_nettype none
module ftx_baud
    import ftx_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // rate control
    ftx_rate_if.gen  rate
);
    logic [FTX_DIV_W-1:0] cnt_q;

    // one tick per nominal bit period of the selected rate
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt_q <= '0;
        end else if (!rate.run) begin
            cnt_q <= '0;
        end else if (cnt_q >= rate.div - 24'h000001) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_q + 24'h000001;
        end
    end

    assign rate.tick = rate.run && (cnt_q >= rate.div - 24'h000001);
endmodule : ftx_baud
`default_nettype wire

// file: ftx_usart.sv
// transmit usart for the fsk modem, axi4-lite slave
//
// The AXI4-Lite register port and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
module ftx_usart
    import ftx_pkg::*;
    #(parameter int CLK_HZ = FTX_CLK_HZ) // system clock in hertz
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rstn,
    // axi4-lite write address
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // axi4-lite write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // axi4-lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // axi4-lite read
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // modulator side
    output logic             tx_bit,
    output logic             fsk_en,
    output logic [3:0]       tx_type,
    output logic [7:0]       rx_mode,
    output logic             powersave,
    // interrupt
    output logic             irq
);
    typedef enum {S_IDLE, S_START, S_DATA, S_PAR, S_STOP, S_HOLD} ftx_st_t;

    ftx_st_t     st_q;
    logic [15:0] mode_q;
    logic [7:0]  rxm_q;
    logic [7:0]  dreg_q;
    logic        full_q;
    logic [7:0]  buf_q;
    logic [3:0]  bit_q;
    logic        stop_q;
    logic        par_q;
    logic        out_q;
    logic [1:0]  sts_q;
    logic [1:0]  ien_q;
    logic [1:0]  evt;
    logic        load;
    logic [1:0]  icl;
    logic        wr_do;
    logic        rd_do;
    logic [7:0]  aw_q;
    logic        awh_q;
    logic [31:0] wd_q;
    logic [3:0]  ws_q;
    logic        wh_q;
    logic [3:0]  mtype;
    logic [1:0]  fmt;
    logic [2:0]  last;
    logic        fsk;
    logic        txfer;

    ftx_rate_if rate ();

    ftx_baud u_baud (
        .clk  (clk),
        .rstn (rstn),
        .rate (rate.gen)
    );

    assign mtype = mode_q[FTX_MD_TYPE_LSB +: 4];
    assign fmt   = mode_q[FTX_MD_FMT_LSB +: 2];
    assign last  = 3'(mode_q[FTX_MD_LEN_LSB +: 2] + 2'd0) + 3'h4;

    // modem type picks the bit-rate divider
    always_comb begin
        unique case (mtype)
            FTX_T_B103:    rate.div = FTX_DIV_W'(CLK_HZ / 300);
            FTX_T_V23_HI:  rate.div = FTX_DIV_W'(CLK_HZ / 1200);
            FTX_T_V23_LO:  rate.div = FTX_DIV_W'(CLK_HZ / 75);
            FTX_T_B202_HI: rate.div = FTX_DIV_W'(CLK_HZ / 1200);
            FTX_T_B202_LO: rate.div = FTX_DIV_W'(CLK_HZ / 150);
            default:       rate.div = FTX_DIV_W'(CLK_HZ / 1200);
        endcase
    end

    // only the fsk types feed the modulator
    assign fsk = (mtype >= FTX_T_B103) && (mtype <= FTX_T_B202_LO);
    assign rate.run = fsk && !mode_q[FTX_MD_PSAVE];

    // ---- axi4-lite write path: address and data taken in either order
    assign s_axi_awready = !awh_q && !s_axi_bvalid;
    assign s_axi_wready  = !wh_q && !s_axi_bvalid;
    assign wr_do = awh_q && wh_q && !s_axi_bvalid;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            awh_q <= 1'b0;
            aw_q  <= 8'h00;
        end else if (s_axi_awvalid && s_axi_awready) begin
            awh_q <= 1'b1;
            aw_q  <= s_axi_awaddr;
        end else if (wr_do) begin
            awh_q <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wh_q <= 1'b0;
            wd_q <= 32'h00000000;
            ws_q <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            wh_q <= 1'b1;
            wd_q <= s_axi_wdata;
            ws_q <= s_axi_wstrb;
        end else if (wr_do) begin
            wh_q <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s_axi_bvalid <= 1'b0;
        end else if (wr_do) begin
            s_axi_bvalid <= 1'b1;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end
    assign s_axi_bresp = 2'b00;

    // transmit and receive modes live in separate registers
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            mode_q <= FTX_MODE_RST;
            rxm_q  <= 8'h00;
            ien_q  <= 2'h0;
        end else if (wr_do) begin
            if (aw_q == FTX_OFF_MODE) begin
                if (ws_q[0]) mode_q[7:0]  <= wd_q[7:0];
                if (ws_q[1]) mode_q[15:8] <= wd_q[15:8];
            end
            if (aw_q == FTX_OFF_RXMODE && ws_q[0]) rxm_q <= wd_q[7:0];
            if (aw_q == FTX_OFF_IEN && ws_q[0]) ien_q <= wd_q[1:0];
        end
    end

    // host load of the eight-bit data register
    assign load = wr_do && (aw_q == FTX_OFF_DATA) && ws_q[0];
    assign icl  = (wr_do && aw_q == FTX_OFF_ICLR && ws_q[0]) ? wd_q[1:0]
                                                              : 2'h0;

    // ---- axi4-lite read path
    assign s_axi_arready = !s_axi_rvalid;
    assign rd_do = s_axi_arvalid && s_axi_arready;
    assign s_axi_rresp = 2'b00;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h00000000;
        end else if (rd_do) begin
            s_axi_rvalid <= 1'b1;
            unique case (s_axi_araddr)
                FTX_OFF_DATA:   s_axi_rdata <= {24'h000000, dreg_q};
                FTX_OFF_MODE:   s_axi_rdata <= {16'h0000, mode_q};
                FTX_OFF_STAT:   s_axi_rdata <= {30'h0, sts_q};
                FTX_OFF_IEN:    s_axi_rdata <= {30'h0, ien_q};
                FTX_OFF_RXMODE: s_axi_rdata <= {24'h000000, rxm_q};
                default:        s_axi_rdata <= 32'h00000000;
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ---- transmitter
    // a transfer point is a tick at which a new character would start
    assign txfer = rate.tick && (fmt != FTX_F_PAT) &&
                   ((st_q == S_IDLE) || (st_q == S_HOLD) ||
                    (st_q == S_DATA && fmt == FTX_F_SYNC && bit_q == 4'h8) ||
                    (st_q == S_STOP && !stop_q));

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            dreg_q <= 8'h00;
            full_q <= 1'b0;
        end else if (load) begin
            dreg_q <= wd_q[7:0];
            full_q <= 1'b1;
        end else if (txfer) begin
            full_q <= 1'b0;
        end
    end

    // sticky events: ready on transfer, underflow on empty
    assign evt[FTX_ST_READY] = txfer && full_q && !load;
    assign evt[FTX_ST_UNDER] = txfer && !full_q && !load &&
                               (st_q != S_IDLE);

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sts_q <= 2'h0;
        end else begin
            // set wins over clear; a load drops the ready flag
            sts_q <= evt | (sts_q & ~icl);
            if (load && !evt[FTX_ST_READY]) begin
                sts_q[FTX_ST_READY] <= 1'b0;
            end
        end
    end
    assign irq = |(sts_q & ien_q);

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st_q   <= S_IDLE;
            buf_q  <= 8'h00;
            bit_q  <= 4'h0;
            stop_q <= 1'b0;
            par_q  <= 1'b0;
            out_q  <= 1'b1;
        end else if (!rate.run) begin
            st_q  <= S_IDLE;
            out_q <= 1'b1;
        end else if (fmt == FTX_F_PAT) begin
            st_q <= S_IDLE;
            if (rate.tick) begin     // continuous patterns
                unique case (mode_q[FTX_MD_PAT_LSB +: 2])
                    2'h0:    out_q <= 1'b1;
                    2'h1:    out_q <= 1'b0;
                    default: out_q <= ~out_q;
                endcase
            end
        end else if (txfer && full_q) begin
            buf_q <= dreg_q;
            bit_q <= 4'h0;
            par_q <= mode_q[FTX_MD_PODD];
            if (fmt == FTX_F_SYNC) begin
                st_q  <= S_DATA;
                out_q <= dreg_q[0];
                par_q <= 1'b0;
                bit_q <= 4'h1;
            end else begin
                st_q  <= S_START;
                out_q <= 1'b0;       // generated start bit
            end
        end else if (txfer) begin
            if (fmt == FTX_F_SYNC && st_q != S_IDLE) begin
                st_q  <= S_DATA;     // resend the same buffer
                out_q <= buf_q[0];
                bit_q <= 4'h1;
            end else begin
                st_q  <= (st_q == S_IDLE) ? S_IDLE : S_HOLD;
                out_q <= 1'b1;       // steady stop level
            end
        end else if (rate.tick) begin
            unique case (st_q)
                S_START: begin
                    st_q  <= S_DATA;
                    out_q <= buf_q[0];
                    par_q <= par_q ^ buf_q[0];
                    bit_q <= 4'h1;
                end
                S_DATA: begin
                    // count runs to last plus one so the last data bit keeps its slot
                    if (fmt == FTX_F_SS && bit_q > {1'b0, last}) begin
                        if (mode_q[FTX_MD_PEN]) begin
                            st_q  <= S_PAR;
                            out_q <= par_q;
                        end else begin
                            st_q   <= S_STOP;
                            out_q  <= 1'b1;
                            stop_q <= mode_q[FTX_MD_STOP2];
                        end
                    end else begin
                        out_q <= buf_q[bit_q[2:0]]; // lsb first
                        par_q <= par_q ^ buf_q[bit_q[2:0]];
                        bit_q <= bit_q + 4'h1;
                    end
                end
                S_PAR: begin
                    st_q   <= S_STOP;
                    out_q  <= 1'b1;
                    stop_q <= mode_q[FTX_MD_STOP2];
                end
                S_STOP: begin
                    stop_q <= 1'b0;  // second stop bit
                end
                default: ;
            endcase
        end
    end

    assign tx_bit    = out_q;
    assign fsk_en    = rate.run;
    assign tx_type   = mtype;
    assign rx_mode   = rxm_q;
    assign powersave = mode_q[FTX_MD_PSAVE];

    a_idle_high: assert property (@(posedge clk) disable iff (!rstn)
        !rate.run |=> tx_bit)
        else $error("output not high while stopped");

    a_ready_clr: assert property (@(posedge clk) disable iff (!rstn)
        (load && !evt[FTX_ST_READY]) |=> !sts_q[FTX_ST_READY])
        else $error("ready not cleared by load");

    a_ready_set: assert property (@(posedge clk) disable iff (!rstn)
        evt[FTX_ST_READY] |=> sts_q[FTX_ST_READY] && !full_q)
        else $error("ready not set on transfer");

    a_under_set: assert property (@(posedge clk) disable iff (!rstn)
        evt[FTX_ST_UNDER] |=> sts_q[FTX_ST_UNDER])
        else $error("underflow not flagged");

    a_start_low: assert property (@(posedge clk) disable iff (!rstn)
        (txfer && full_q && rate.run && fmt == FTX_F_SS)
        |=> !tx_bit && st_q == S_START)
        else $error("start bit missing");

    a_ss_hold: assert property (@(posedge clk) disable iff (!rstn)
        (st_q == S_HOLD && !full_q && !load && rate.run)
        |=> tx_bit)
        else $error("stop level not held on underflow");

    a_sync_first: assert property (@(posedge clk) disable iff (!rstn)
        (txfer && full_q && rate.run && fmt == FTX_F_SYNC)
        |=> tx_bit == $past(dreg_q[0]))
        else $error("sync bit zero not first");

    a_sync_resend: assert property (@(posedge clk) disable iff (!rstn)
        (txfer && !full_q && !load && rate.run && fmt == FTX_F_SYNC
         && st_q != S_IDLE) |=> tx_bit == buf_q[0])
        else $error("sync buffer not resent");

    a_psave_off: assert property (@(posedge clk) disable iff (!rstn)
        powersave |-> !fsk_en)
        else $error("usart active in powersave");
endmodule : ftx_usart
`default_nettype wire

// file: ftx_host.sv
// axi4-lite host model that loads the usart registers
`timescale 1ns/1ps
`default_nettype none
module ftx_host (
    // clock
    input  wire logic        clk,
    // write channels
    output logic [7:0]       awaddr,
    output logic             awvalid,
    input  wire logic        awready,
    output logic [31:0]      wdata,
    output logic [3:0]       wstrb,
    output logic             wvalid,
    input  wire logic        wready,
    input  wire logic        bvalid,
    output logic             bready,
    // read channels
    output logic [7:0]       araddr,
    output logic             arvalid,
    input  wire logic        arready,
    input  wire logic [31:0] rdata,
    input  wire logic        rvalid,
    output logic             rready
);
    int timeouts;

    initial begin
        {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
        {araddr, arvalid, rready} = '0;
        timeouts = 0;
    end

    // host hands one whole word per write, the usart takes what it needs
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        awaddr  <= a;
        awvalid <= 1'b1;
        wdata   <= d;
        wstrb   <= 4'hF;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        for (n = 0; n < 1000; n++) begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid === 1'b1) break;
        end
        bready <= 1'b0;
        if (n == 1000) timeouts++;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        int n;
        d = '0;
        @(posedge clk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        for (n = 0; n < 1000; n++) begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid === 1'b1) begin
                d = rdata;
                break;
            end
        end
        rready <= 1'b0;
        if (n == 1000) timeouts++;
    endtask : rd
endmodule : ftx_host
`default_nettype wire

// file: ftx_usart_tb.sv
// self-checking bench for the transmit usart
`timescale 1ns/1ps
`default_nettype none
module ftx_usart_tb;
    import ftx_pkg::*;
    logic        clk, rstn;
    logic [7:0]  awaddr, araddr;
    logic        awvalid, awready, wvalid, wready, bvalid, bready;
    logic [31:0] wdata, rdata, v;
    logic [3:0]  wstrb, tx_type;
    logic [1:0]  bresp, rresp;
    logic        arvalid, arready, rvalid, rready;
    logic        tx_bit, fsk_en, powersave, irq;
    logic [7:0]  rx_mode;
    int          fail_count, checked, n;
    logic [15:0] w;
    // short bit periods keep whole frames inside the run
    localparam int TB_HZ   = 24_000;
    localparam int BIT_CYC = TB_HZ / 1200;

    ftx_usart #(.CLK_HZ(TB_HZ)) DUT (.clk(clk), .rstn(rstn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .tx_bit(tx_bit),
        .fsk_en(fsk_en), .tx_type(tx_type), .rx_mode(rx_mode),
        .powersave(powersave), .irq(irq));

    ftx_host host (.clk(clk), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(wready), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata),
        .rvalid(rvalid), .rready(rready));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic wrap_up;
        if (fail_count == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : wrap_up

    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    // a bus hang ends the run at once
    task automatic bus_guard;
        if (host.timeouts != 0) begin
            fail_count++;
            $display("FAIL %0t bus handshake timed out", $time);
            wrap_up();
        end
    endtask : bus_guard

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        host.wr(a, d);
        bus_guard();
    endtask : wr

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp,
                          input string what);
        host.rd(a, v);
        bus_guard();
        chk(v, exp, what);
    endtask : rd_chk

    // wait for the line to fall, then sample each bit in its middle
    task automatic grab(input int nb, output logic [15:0] got);
        int i;
        got = 16'h0000;
        for (i = 0; i < 2000; i++) begin
            if (tx_bit === 1'b0) break;
            @(posedge clk);
        end
        if (i == 2000) begin
            fail_count++;
            $display("FAIL %0t line never fell", $time);
            wrap_up();
        end
        repeat (BIT_CYC / 2) @(posedge clk);
        for (i = 0; i < nb; i++) begin
            got[i] = tx_bit;
            repeat (BIT_CYC) @(posedge clk);
        end
    endtask : grab

    initial begin
        fail_count = 0;
        checked = 0;
        rstn = 1'b0;
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        chk({31'h0, tx_bit}, 32'h1, "idle line");
        chk({31'h0, irq}, 32'h0, "irq after reset");
        rd_chk(FTX_OFF_MODE, 32'h0, "mode reset");
        rd_chk(FTX_OFF_STAT, 32'h0, "status reset");
        // every transmit type; only the fsk modem types feed the modulator
        for (n = 0; n < 9; n++) begin
            wr(FTX_OFF_MODE, 32'(n));
            chk({28'h0, tx_type}, 32'(n), "tx type");
            chk({31'h0, fsk_en}, {31'h0, (n >= 1 && n <= 5)},
                "fsk enable");
        end
        wr(FTX_OFF_MODE, 32'h0000_8004);
        chk({31'h0, powersave}, 32'h1, "powersave");
        chk({31'h0, fsk_en}, 32'h0, "fsk off in powersave");
        chk({31'h0, tx_bit}, 32'h1, "line rests in powersave");
        wr(FTX_OFF_RXMODE, 32'h5A);
        rd_chk(FTX_OFF_RXMODE, 32'h5A, "rx mode readback");
        chk({24'h0, rx_mode}, 32'h5A, "rx mode port");
        rd_chk(FTX_OFF_MODE, 32'h8004, "tx mode kept");
        rd_chk(8'h18, 32'h0, "unmapped read");
        wr(FTX_OFF_STAT, 32'h3);
        rd_chk(FTX_OFF_STAT, 32'h0, "status is read only");
        wr(FTX_OFF_IEN, 32'h3);
        rd_chk(FTX_OFF_IEN, 32'h3, "irq enable readback");
        // bell 202 at 1200, synchronous data, bit zero of 0xA6 is low
        wr(FTX_OFF_MODE, 32'h4);
        wr(FTX_OFF_DATA, 32'hA6);
        rd_chk(FTX_OFF_STAT, 32'h0, "ready low after load");
        for (n = 0; n < 90000; n++) begin
            @(posedge clk);
            if (tx_bit !== 1'b1) break;
        end
        if (n == 90000) begin
            fail_count++;
            $display("FAIL %0t no bit left the line", $time);
            wrap_up();
        end
        chk({31'h0, tx_bit}, 32'h0, "first sync bit is bit zero");
        rd_chk(FTX_OFF_STAT, 32'h1, "ready after transfer");
        chk({31'h0, irq}, 32'h1, "irq raised");
        wr(FTX_OFF_IEN, 32'h0);
        chk({31'h0, irq}, 32'h0, "irq masked");
        wr(FTX_OFF_IEN, 32'h1);
        chk({31'h0, irq}, 32'h1, "irq unmasked");
        wr(FTX_OFF_ICLR, 32'h1);
        chk({31'h0, irq}, 32'h0, "irq cleared");
        rd_chk(FTX_OFF_STAT, 32'h0, "status cleared");
        wr(FTX_OFF_DATA, 32'h11);
        rd_chk(FTX_OFF_DATA, 32'h11, "data readback");
        // start-stop, 8 bits, even parity: the waiting 0x11 goes out
        wr(FTX_OFF_MODE, 32'h0);
        wr(FTX_OFF_MODE, 32'h01D4);
        grab(11, w);
        // stop 1, parity 0, data 0x11, start 0
        chk({16'h0, w}, 32'h0422, "ss frame 8e1");
        repeat (2 * BIT_CYC) @(posedge clk);
        chk({31'h0, tx_bit}, 32'h1, "stop level on underflow");
        rd_chk(FTX_OFF_STAT, 32'h3, "underflow after frame");
        // 5 data bits, odd parity, two stops
        wr(FTX_OFF_MODE, 32'h0);
        wr(FTX_OFF_DATA, 32'h35);
        rd_chk(FTX_OFF_STAT, 32'h2, "ready cleared by load");
        wr(FTX_OFF_MODE, 32'h0714);
        grab(9, w);
        chk({16'h0, w}, 32'h01AA, "ss frame 5o2");
        // alternating pattern
        wr(FTX_OFF_MODE, 32'h0);
        wr(FTX_OFF_MODE, 32'h2024);
        grab(4, w);
        chk({16'h0, w}, 32'h000A, "alternating pattern");
        // sync underflow repeats the buffer
        wr(FTX_OFF_MODE, 32'h0);
        wr(FTX_OFF_ICLR, 32'h3);
        wr(FTX_OFF_DATA, 32'h5C);
        wr(FTX_OFF_MODE, 32'h4);
        grab(16, w);
        chk({16'h0, w}, 32'h5C5C, "sync byte then resend");
        rd_chk(FTX_OFF_STAT, 32'h3, "sync underflow flagged");
        wrap_up();
    end
endmodule : ftx_usart_tb
`default_nettype wire
